// ---- design/bbse_pkg.sv ----
// Package with opcodes, flag positions, widths and cycle counts for the branch, bit and shift executor.
package bbse_pkg;

    localparam int PC_W   = 12;
    localparam int K_W    = 7;
    localparam int IOA_W  = 5;
    localparam int DATA_W = 8;

    // Status flag bit positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] SREG_RESET = 8'h00;
    localparam logic [7:0] IO_RESET   = 8'h00;
    localparam logic [2:0] RF_MSB     = 3'h7;

    // Cycle counts.
    localparam int CYC_BR_NOT_TAKEN = 1;
    localparam int CYC_BR_TAKEN     = 2;
    localparam int CYC_IO_BIT       = 2;
    localparam int CYC_SHIFT        = 1;

    typedef enum logic [3:0] {
        OP_NOP                    = 4'h0,
        OP_BRANCH_SIGNED_GE       = 4'h1,
        OP_BRANCH_SIGNED_LT       = 4'h2,
        OP_BRANCH_HALFCARRY_SET   = 4'h3,
        OP_BRANCH_HALFCARRY_CLEAR = 4'h4,
        OP_BRANCH_TRANSFER_SET    = 4'h5,
        OP_BRANCH_TRANSFER_CLEAR  = 4'h6,
        OP_BRANCH_OVERFLOW_SET    = 4'h7,
        OP_BRANCH_OVERFLOW_CLEAR  = 4'h8,
        OP_BRANCH_IRQ_ENABLED     = 4'h9,
        OP_BRANCH_IRQ_DISABLED    = 4'hA,
        OP_IO_BIT_SET             = 4'hB,
        OP_IO_BIT_CLEAR           = 4'hC,
        OP_SHIFT_LEFT_LOGICAL     = 4'hD,
        OP_SHIFT_RIGHT_LOGICAL    = 4'hE
    } bbse_op_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_BRANCH = 2'b01,
        ST_IO_WR  = 2'b10
    } bbse_state_type;

endpackage : bbse_pkg

// ---- design/bbse_shift_unit.sv ----
// Logical shift unit with its flag results.
`timescale 1ns/100ps
`default_nettype none
module bbse_shift_unit
    import bbse_pkg::*;
(
    input  wire logic [DATA_W-1:0] operand_i,   // Destination register value
    input  wire logic              left_i,      // High shifts left, low shifts right
    input  wire logic [7:0]        sreg_i,      // Current status flags
    output logic      [DATA_W-1:0] result_o,    // Shifted value
    output logic      [7:0]        sreg_o       // Updated status flags
);
    import bbse_pkg::*;

    logic carry;
    logic neg;
    logic ovf;

    always_comb begin
        sreg_o = sreg_i;
        if (left_i) begin
            result_o = {operand_i[DATA_W-2:0], 1'b0};
            carry    = operand_i[DATA_W-1];
        end else begin
            result_o = {1'b0, operand_i[DATA_W-1:1]};
            carry    = operand_i[0];
        end
        neg = result_o[DATA_W-1];
        ovf = neg ^ carry;
        sreg_o[FLAG_C] = carry;
        sreg_o[FLAG_Z] = (result_o == '0);
        sreg_o[FLAG_N] = neg;
        sreg_o[FLAG_V] = ovf;
        sreg_o[FLAG_S] = neg ^ ovf;
    end
endmodule : bbse_shift_unit
`default_nettype wire

// ---- design/bbse_exec.sv ----
// Executor for conditional relative branches, I/O bit set and clear, and logical shifts.
//
// Functional notes
// - Signed greater-or-equal branch jumps to PC+k+1 when N xor V is zero.
// - Signed less-than branch jumps to PC+k+1 when N xor V is one.
// - Half-carry branches jump on H set or H clear; flags untouched.
// - Transfer-bit branches jump on T set or T clear; flags untouched.
// - Overflow branches jump on V set or V clear; flags untouched.
// - Interrupt-state branches jump on I set or I clear; flags untouched.
// - I/O bit set forces bit b of register P high in two cycles.
// - I/O bit clear forces bit b of register P low in two cycles.
// - Left shift inserts zero at bit 0 and updates Z, C, N, V.
// - Right shift inserts zero at bit 7 and updates Z, C, N, V.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bbse_exec
    import bbse_pkg::*;
#(
    parameter int NUM_IO  = 32,
    parameter int NUM_REG = 32
) (
    input  wire logic                    core_clk_i,   // Core clock, 250 MHz
    input  wire logic                    rst_i,        // Asynchronous reset, active high
    input  wire logic                    issue_i,      // Instruction presented this cycle
    input  wire bbse_pkg::bbse_op_type   op_i,         // Decoded operation
    input  wire logic [K_W-1:0]          k_i,          // Signed branch offset in words
    input  wire logic [IOA_W-1:0]        io_addr_i,    // I/O register index P
    input  wire logic [2:0]              bit_i,        // Bit index b
    input  wire logic [4:0]              rd_i,         // Destination register index
    input  wire logic                    sreg_we_i,    // External status flag load
    input  wire logic [7:0]              sreg_wdata_i, // Value for external flag load
    input  wire logic                    rf_we_i,      // Load register Rd from rf_wdata_i when idle
    input  wire logic [DATA_W-1:0]       rf_wdata_i,   // Value for register Rd load
    output logic                         ready_o,      // Executor can take an instruction
    output logic      [PC_W-1:0]         pc_o,         // Program counter
    output logic      [7:0]              sreg_o,       // Status flags
    output logic      [DATA_W-1:0]       io_rdata_o,   // Value of I/O register P
    output logic      [DATA_W-1:0]       rf_rdata_o    // Value of register Rd
);
    import bbse_pkg::*;

    logic [DATA_W-1:0] io_q   [NUM_IO];
    logic [DATA_W-1:0] io_d   [NUM_IO];
    logic [DATA_W-1:0] rf_q   [NUM_REG];
    logic [DATA_W-1:0] rf_d   [NUM_REG];
    logic [PC_W-1:0]   pc_q,   pc_d;
    logic [7:0]        sreg_q, sreg_d;
    bbse_state_type    state_q, state_d;
    logic [PC_W-1:0]   target_q, target_d;
    logic [IOA_W-1:0]  io_sel_q, io_sel_d;
    logic [DATA_W-1:0] io_val_q, io_val_d;
    logic [DATA_W-1:0] sh_res;
    logic [7:0]        sh_sreg;
    logic              take;
    logic              accept;
    logic              do_br;
    logic              do_io;
    logic              do_sh;
    logic [PC_W-1:0]   pc_next;

    function automatic logic branch_cond(input bbse_op_type op, input logic [7:0] s);
        case (op)
            OP_BRANCH_SIGNED_GE:       branch_cond = (s[FLAG_N] ^ s[FLAG_V]) == 1'b0;
            OP_BRANCH_SIGNED_LT:       branch_cond = (s[FLAG_N] ^ s[FLAG_V]) == 1'b1;
            OP_BRANCH_HALFCARRY_SET:   branch_cond = s[FLAG_H];
            OP_BRANCH_HALFCARRY_CLEAR: branch_cond = !s[FLAG_H];
            OP_BRANCH_TRANSFER_SET:    branch_cond = s[FLAG_T];
            OP_BRANCH_TRANSFER_CLEAR:  branch_cond = !s[FLAG_T];
            OP_BRANCH_OVERFLOW_SET:    branch_cond = s[FLAG_V];
            OP_BRANCH_OVERFLOW_CLEAR:  branch_cond = !s[FLAG_V];
            OP_BRANCH_IRQ_ENABLED:     branch_cond = s[FLAG_I];
            OP_BRANCH_IRQ_DISABLED:    branch_cond = !s[FLAG_I];
            default:                   branch_cond = 1'b0;
        endcase
    endfunction : branch_cond

    function automatic logic is_branch(input bbse_op_type op);
        is_branch = (op >= OP_BRANCH_SIGNED_GE) && (op <= OP_BRANCH_IRQ_DISABLED);
    endfunction : is_branch

    function automatic logic is_io_bit(input bbse_op_type op);
        is_io_bit = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
    endfunction : is_io_bit

    function automatic logic is_shift(input bbse_op_type op);
        is_shift = (op == OP_SHIFT_LEFT_LOGICAL) || (op == OP_SHIFT_RIGHT_LOGICAL);
    endfunction : is_shift

    bbse_shift_unit u_shift (
        .operand_i (rf_q[rd_i]),
        .left_i    (op_i == OP_SHIFT_LEFT_LOGICAL),
        .sreg_i    (sreg_q),
        .result_o  (sh_res),
        .sreg_o    (sh_sreg)
    );

    assign ready_o    = (state_q == ST_IDLE);
    assign pc_o       = pc_q;
    assign sreg_o     = sreg_q;
    assign io_rdata_o = io_q[io_addr_i];
    assign rf_rdata_o = rf_q[rd_i];

    assign pc_next = pc_q + PC_W'(1);
    assign take    = branch_cond(op_i, sreg_q);

    // An instruction is only taken while idle; a request during a busy cycle is dropped.
    assign accept = issue_i && (state_q == ST_IDLE);
    assign do_br  = accept && is_branch(op_i);
    assign do_io  = accept && is_io_bit(op_i);
    assign do_sh  = accept && is_shift(op_i);

    // Sequencer state, program counter and pending branch target.
    always_comb begin
        state_d  = state_q;
        pc_d     = pc_q;
        target_d = target_q;
        case (state_q)
            ST_IDLE: begin
                if (do_br && take) begin
                    // Sign-extended offset added to PC+1, jump lands in the second cycle.
                    target_d = pc_next + PC_W'($signed(k_i));
                    state_d  = ST_BRANCH;
                end else if (do_io) begin
                    state_d = ST_IO_WR;
                end else if (accept) begin
                    // Untaken branches, shifts and all other operations advance one word.
                    pc_d = pc_next;
                end
            end
            ST_BRANCH: begin
                pc_d    = target_q;
                state_d = ST_IDLE;
            end
            ST_IO_WR: begin
                pc_d    = pc_next;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= ST_IDLE;
            pc_q     <= '0;
            target_q <= '0;
        end else begin
            state_q  <= state_d;
            pc_q     <= pc_d;
            target_q <= target_d;
        end
    end

    // Status flags: an outside load applies only while idle, and a shift issued beside it wins.
    always_comb begin
        sreg_d = sreg_q;
        if (state_q == ST_IDLE && sreg_we_i) begin
            sreg_d = sreg_wdata_i;
        end
        if (do_sh) begin
            sreg_d = sh_sreg;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sreg_q <= SREG_RESET;
        end else begin
            sreg_q <= sreg_d;
        end
    end

    // I/O registers: the old value is read in the first cycle and written back in the second.
    always_comb begin
        io_sel_d = io_sel_q;
        io_val_d = io_val_q;
        io_d     = io_q;
        if (do_io) begin
            io_sel_d        = io_addr_i;
            io_val_d        = io_q[io_addr_i];
            io_val_d[bit_i] = (op_i == OP_IO_BIT_SET);
        end
        if (state_q == ST_IO_WR) begin
            io_d[io_sel_q] = io_val_q;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_sel_q <= '0;
            io_val_q <= '0;
            for (int i = 0; i < NUM_IO; i++) begin
                io_q[i] <= IO_RESET;
            end
        end else begin
            io_sel_q <= io_sel_d;
            io_val_q <= io_val_d;
            io_q     <= io_d;
        end
    end

    // Register file: an outside load fills Rd while idle, and a shift issued beside it wins.
    always_comb begin
        rf_d = rf_q;
        if (state_q == ST_IDLE && rf_we_i) begin
            rf_d[rd_i] = rf_wdata_i;
        end
        if (do_sh) begin
            rf_d[rd_i] = sh_res;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REG; i++) begin
                rf_q[i] <= '0;
            end
        end else begin
            rf_q <= rf_d;
        end
    end
endmodule : bbse_exec
`default_nettype wire

// ---- tb/bbse_exec_checker.sv ----
// Checker with timing and result assertions for the branch, bit and shift executor.
`timescale 1ns/100ps
`default_nettype none
module bbse_exec_checker
    import bbse_pkg::*;
(
    input wire logic                 core_clk_i, // Clock
    input wire logic                 rst_i,      // Reset
    input wire logic                 issue_i,    // Issue
    input wire bbse_pkg::bbse_op_type op_i,      // Operation
    input wire logic [K_W-1:0]       k_i,        // Offset
    input wire logic [IOA_W-1:0]     io_addr_i,  // I/O index
    input wire logic [2:0]           bit_i,      // Bit index
    input wire logic [4:0]           rd_i,       // Register index
    input wire logic                 sreg_we_i,  // Flag load
    input wire logic                 ready_o,    // Ready
    input wire logic [PC_W-1:0]      pc_o,       // Program counter
    input wire logic [7:0]           sreg_o,     // Flags
    input wire logic [DATA_W-1:0]    io_rdata_o, // I/O value
    input wire logic [DATA_W-1:0]    rf_rdata_o  // Register value
);
    logic            go;
    logic            br;
    logic            hit;
    logic [4:0]      g;
    logic [PC_W-1:0] tgt;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Conditions sit in pairs, the odd opcode of each pair taking the true sense.
    always_comb begin
        go  = issue_i && ready_o && !sreg_we_i;
        br  = op_i >= OP_BRANCH_SIGNED_GE && op_i <= OP_BRANCH_IRQ_DISABLED;
        g   = {sreg_o[FLAG_I], sreg_o[FLAG_V], sreg_o[FLAG_T], sreg_o[FLAG_H], !(sreg_o[FLAG_N] ^ sreg_o[FLAG_V])};
        hit = g[3'((op_i - 4'h1) >> 1)] ^ !op_i[0];
        tgt = pc_o + 12'h001 + {{(PC_W-K_W){k_i[K_W-1]}}, k_i};
    end
    chk_br_flags: assert property (go && br |=> $stable(sreg_o))
        else $error("Branch altered flags");
    chk_br_untaken: assert property (go && br && !hit |=> ready_o && pc_o == $past(pc_o) + 12'h001)
        else $error("Untaken branch wrong");
    chk_br_taken: assert property (go && br && hit |=> !ready_o ##1 ready_o && pc_o == $past(tgt, 2))
        else $error("Taken branch wrong");
    chk_io_timing: assert property (go && (op_i == OP_IO_BIT_SET || op_i == OP_IO_BIT_CLEAR)
        |=> !ready_o && $stable(sreg_o) ##1 ready_o && pc_o == $past(pc_o, 2) + 12'h001)
        else $error("Bit operation timing wrong");
    chk_io_set: assert property (go && op_i == OP_IO_BIT_SET ##1 $stable(io_addr_i)
        ##1 $stable(io_addr_i) |-> io_rdata_o == ($past(io_rdata_o, 2) | (8'h01 << $past(bit_i, 2))))
        else $error("Bit set wrong");
    chk_io_clear: assert property (go && op_i == OP_IO_BIT_CLEAR ##1 $stable(io_addr_i)
        ##1 $stable(io_addr_i) |-> io_rdata_o == ($past(io_rdata_o, 2) & ~(8'h01 << $past(bit_i, 2))))
        else $error("Bit clear wrong");
    chk_shift_left: assert property (go && op_i == OP_SHIFT_LEFT_LOGICAL ##1 $stable(rd_i)
        |-> rf_rdata_o == {$past(rf_rdata_o[6:0]), 1'b0} && sreg_o[FLAG_C] == $past(rf_rdata_o[7])
        && sreg_o[FLAG_Z] == (rf_rdata_o == 8'h00) && sreg_o[FLAG_N] == rf_rdata_o[7]
        && sreg_o[FLAG_V] == (rf_rdata_o[7] ^ $past(rf_rdata_o[7])) && pc_o == $past(pc_o) + 12'h001)
        else $error("Left shift wrong");
    chk_shift_right: assert property (go && op_i == OP_SHIFT_RIGHT_LOGICAL ##1 $stable(rd_i)
        |-> rf_rdata_o == {1'b0, $past(rf_rdata_o[7:1])} && sreg_o[FLAG_C] == $past(rf_rdata_o[0])
        && !sreg_o[FLAG_N] && sreg_o[FLAG_V] == $past(rf_rdata_o[0]) && sreg_o[FLAG_Z] == (rf_rdata_o == 8'h00)
        && pc_o == $past(pc_o) + 12'h001)
        else $error("Right shift wrong");
endmodule : bbse_exec_checker
bind bbse_exec bbse_exec_checker u_chk (.core_clk_i, .rst_i, .issue_i, .op_i, .k_i, .io_addr_i, .bit_i, .rd_i,
    .sreg_we_i, .ready_o, .pc_o, .sreg_o, .io_rdata_o, .rf_rdata_o);
`default_nettype wire

// ---- tb/tb_bbse_exec.sv ----
// Self-checking testbench for the branch, bit and shift executor.
`timescale 1ns/100ps
`default_nettype none
module tb_bbse_exec;
    import bbse_pkg::*;
    typedef struct packed {
        bbse_op_type    op;
        logic [7:0]     st;
        logic [7:0]     sf;
        logic [K_W-1:0] k;
    } bbse_row_type;
    logic core_clk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, sreg_we_i = 1'b0, rf_we_i = 1'b0, ready_o;
    bbse_op_type op_i = OP_NOP;
    logic [K_W-1:0] k_i = '0;
    logic [4:0] io_addr_i = '0, rd_i = '0;
    logic [2:0] bit_i = '0;
    logic [7:0] sreg_wdata_i = '0, rf_wdata_i = '0, sreg_o, io_rdata_o, rf_rdata_o, s;
    logic [PC_W-1:0] pc_o, ep = '0;
    int fail_count = 0, cmp_count = 0, n;
    bbse_row_type rows [10] = '{'{OP_BRANCH_SIGNED_GE, 8'h0C, 8'h04, 7'h3F}, '{OP_BRANCH_SIGNED_LT, 8'h08, 8'h0C, 7'h40},
        '{OP_BRANCH_HALFCARRY_SET, 8'h20, 8'hDF, 7'h01}, '{OP_BRANCH_HALFCARRY_CLEAR, 8'hDF, 8'h20, 7'h7F},
        '{OP_BRANCH_TRANSFER_SET, 8'h40, 8'hBF, 7'h3F}, '{OP_BRANCH_TRANSFER_CLEAR, 8'hBF, 8'h40, 7'h40},
        '{OP_BRANCH_OVERFLOW_SET, 8'h08, 8'hF7, 7'h02}, '{OP_BRANCH_OVERFLOW_CLEAR, 8'hF7, 8'h08, 7'h7E},
        '{OP_BRANCH_IRQ_ENABLED, 8'h80, 8'h7F, 7'h3F}, '{OP_BRANCH_IRQ_DISABLED, 8'h7F, 8'h80, 7'h40}};
    bbse_exec DUT (.core_clk_i, .rst_i, .issue_i, .op_i, .k_i, .io_addr_i, .bit_i, .rd_i, .sreg_we_i,
        .sreg_wdata_i, .rf_we_i, .rf_wdata_i, .ready_o, .pc_o, .sreg_o, .io_rdata_o, .rf_rdata_o);
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic setf(input logic [7:0] v);
        @(posedge core_clk_i); sreg_we_i <= 1'b1; sreg_wdata_i <= v;
        @(posedge core_clk_i); sreg_we_i <= 1'b0;
    endtask : setf
    task automatic wreg(input logic [4:0] r, input logic [7:0] v);
        @(posedge core_clk_i);
        rf_we_i    <= 1'b1;
        rd_i       <= r;
        rf_wdata_i <= v;
        @(posedge core_clk_i);
        rf_we_i    <= 1'b0;
    endtask : wreg
    // Issues one instruction and counts cycles until the executor is ready again.
    task automatic run(input bbse_op_type o, input logic [K_W-1:0] k, input logic [4:0] p, input logic [2:0] b,
                       output int c);
        @(posedge core_clk_i); issue_i <= 1'b1; op_i <= o; k_i <= k; io_addr_i <= p; rd_i <= p; bit_i <= b;
        @(posedge core_clk_i); issue_i <= 1'b0; c = 1; #1;
        while (ready_o !== 1'b1 && c < 8) begin
            @(posedge core_clk_i); c++; #1;
        end
    endtask : run
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #20000; fail_count++; conclude();
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            for (int t = 0; t < 2; t++) begin
                s = t ? rows[i].sf : rows[i].st;
                setf(s);
                run(rows[i].op, rows[i].k, 5'h00, 3'h0, n);
                ep = t ? ep + 12'h001 : ep + 12'h001 + {{(PC_W-K_W){rows[i].k[K_W-1]}}, rows[i].k};
                chk(pc_o, ep);
                chk(16'(n), t ? 16'(CYC_BR_NOT_TAKEN) : 16'(CYC_BR_TAKEN));
                chk(sreg_o, s);
            end
        end
        setf(8'hFF);
        run(OP_IO_BIT_SET, 7'h00, 5'h1F, 3'h7, n);
        chk(16'(n), 16'(CYC_IO_BIT));
        chk(io_rdata_o, 8'h80);
        run(OP_IO_BIT_SET, 7'h00, 5'h1F, 3'h0, n);
        chk(io_rdata_o, 8'h81);
        run(OP_IO_BIT_CLEAR, 7'h00, 5'h1F, 3'h7, n);
        chk(io_rdata_o, 8'h01);
        chk(sreg_o, 8'hFF);
        chk(pc_o, ep + 12'h003);
        run(OP_SHIFT_LEFT_LOGICAL, 7'h00, 5'h03, 3'h0, n);
        chk(sreg_o, 8'hE2);
        chk(16'(n), 16'(CYC_SHIFT));
        setf(8'hFF);
        run(OP_SHIFT_RIGHT_LOGICAL, 7'h00, 5'h03, 3'h0, n);
        chk(sreg_o, 8'hE2);
        chk(rf_rdata_o, 8'h00);
        setf(8'hFF);
        wreg(5'h03, 8'hC3);
        run(OP_SHIFT_LEFT_LOGICAL, 7'h00, 5'h03, 3'h0, n);
        chk(rf_rdata_o, 8'h86);
        chk(sreg_o, 8'hF5);
        run(OP_SHIFT_RIGHT_LOGICAL, 7'h00, 5'h03, 3'h0, n);
        chk(rf_rdata_o, 8'h43);
        chk(sreg_o, 8'hE0);
        chk(16'(n), 16'(CYC_SHIFT));
        @(posedge core_clk_i); rst_i <= 1'b1; io_addr_i <= 5'h1F;
        #1; chk(pc_o, 12'h000);
        chk(io_rdata_o, IO_RESET);
        chk(sreg_o, SREG_RESET);
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        // Flags are clear after reset, so the interrupt-disabled branch is taken at once.
        run(OP_BRANCH_IRQ_DISABLED, 7'h05, 5'h00, 3'h0, n);
        chk(pc_o, 12'h006);
        chk(16'(n), 16'(CYC_BR_TAKEN));
        conclude();
    end
endmodule : tb_bbse_exec
`default_nettype wire
